/* rtl/pdss_pkg.sv */
// constants and carriers of the pwm dead-band and steering stage
// assumes a 50 MHz REF_CLK and an APB master with 32-bit data
//
// How it works
// [RULE1] half-bridge delays only inactive-to-active edges
// [RULE2] dead band counted in four-clock instruction cycles
// [RULE3] count equals cycles between scheduled and actual
// [RULE4] auto-restart clears shutdown status when fault goes; code keeps it set until the next period start
// [RULE5] without auto-restart software clears shutdown status; code keeps it set until the next period start after the clear
// [RULE6] steering only in single-output mode
// [RULE7] steer enable routes pwm, else port control
// [RULE8] one waveform on any set of pins
// [RULE9] mode low bits set steered polarity
// [RULE10] shutdown forces only steered pins
// [RULE11] sync clear: steering updates immediately
// [RULE12] sync set: steering updates at next period
// [RULE13] sleep freezes timer, state and outputs
// [RULE14] idle keeps primary clock, others use selected
// [RULE15] pwm reaches pin only when direction is output
// [RULE16] software sets a steer enable for output
// [RULE17] shutdown forces pins to programmed pair levels
// [RULE18] restart resumes at next period start
// [RULE19] zero count adds no delay
package pdss_pkg;
    // ***************************************************************
    // register map
    // ***************************************************************
    localparam logic [11:0] PDSS_ADDR_DBR   = 12'h000;
    localparam logic [11:0] PDSS_ADDR_STEER = 12'h004;
    localparam logic [11:0] PDSS_ADDR_MODE  = 12'h008;
    localparam logic [11:0] PDSS_ADDR_SHUT  = 12'h00c;
    localparam logic [11:0] PDSS_ADDR_STAT  = 12'h010;
    localparam logic [7:0]  PDSS_RST_DBR    = 8'h00;
    localparam logic [4:0]  PDSS_RST_STEER  = 5'h01;
    localparam logic [7:0]  PDSS_RST_MODE   = 8'h00;
    localparam logic [7:0]  PDSS_RST_SHUT   = 8'h00;
    localparam int          PDSS_RESTART_BIT = 7;
    localparam int          PDSS_SHUT_BIT    = 7;
    localparam int          PDSS_SYNC_BIT    = 4;
    // ***************************************************************
    // mode encodings
    // ***************************************************************
    localparam logic [1:0] PDSS_MODE_PWM    = 2'h3;
    localparam logic [1:0] PDSS_BR_SINGLE   = 2'h0;
    localparam logic [1:0] PDSS_BR_HALF     = 2'h2;
    localparam logic [1:0] PDSS_SS_LOW      = 2'h0;
    localparam logic [1:0] PDSS_SS_HIGH     = 2'h1;
    // ***************************************************************
    // timing
    // ***************************************************************
    localparam int          PDSS_CLK_MHZ   = 50;
    localparam int          PDSS_TCY_OSC   = 4;
    localparam logic [1:0]  PDSS_TCY_LAST  = 2'(PDSS_TCY_OSC - 1);
    localparam logic [7:0]  PDSS_PERIOD_RST = 8'hff;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } pdss_pins_s;

    typedef enum logic [2:0] {
        PDSS_RUN  = 3'b001,
        PDSS_SHUT = 3'b010,
        PDSS_WAIT = 3'b100
    } pdss_state_e;
endpackage

/* rtl/pdss_stage.sv */
// output stage: dead band, auto-restart and pulse steering
// assumes pwm, period start and shutdown inputs come from outside pins
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module pdss_stage (
    input  wire logic        REF_CLK,
    input  wire logic        RSTN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        PWM_IN,
    input  wire logic        PERIOD_START,
    input  wire logic        SHUTDOWN_IN,
    input  wire logic        SLEEP,
    input  wire logic        PM_TICK,
    input  wire logic        PM_CLK_SEL,
    input  wire logic [3:0]  PIN_DIRECTION_BITS,
    input  wire logic [3:0]  PORT_OUT,
    output logic      [3:0]  PWM_OUT,
    output logic      [3:0]  PWM_OE
);
    // ***************************************************************
    // input synchronisers
    // ***************************************************************
    logic [3:0] s1;
    logic [3:0] s2;
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            s1 <= 4'h0;
            s2 <= 4'h0;
        end else begin
            s1 <= {PWM_IN, PERIOD_START, SHUTDOWN_IN, PM_TICK};
            s2 <= s1;
        end
    end
    wire pwm_raw  = s2[3];
    wire per_lvl  = s2[2];
    wire fault    = s2[1];
    wire pm_tick  = s2[0];
    logic per_d;
    // sleep stops the dead band, period edge, state and pins; pm clock gives only selected ticks
    wire  run     = !SLEEP && (!PM_CLK_SEL || pm_tick);  // [RULE13] [RULE14]
    wire  per_start = run && per_lvl && !per_d;

    // ***************************************************************
    // registers
    // ***************************************************************
    logic [7:0] dbr;
    logic [4:0] steer;
    logic [3:0] steer_eff;
    logic [7:0] mode;
    logic [7:0] shut;
    pdss_pkg::pdss_state_e st;
    wire acc   = PSEL && PENABLE;
    wire wr    = acc && PWRITE;
    wire a_dbr = PADDR == pdss_pkg::PDSS_ADDR_DBR;
    wire a_str = PADDR == pdss_pkg::PDSS_ADDR_STEER;
    wire a_mod = PADDR == pdss_pkg::PDSS_ADDR_MODE;
    wire a_sht = PADDR == pdss_pkg::PDSS_ADDR_SHUT;
    wire a_sta = PADDR == pdss_pkg::PDSS_ADDR_STAT;
    wire mapped = a_dbr || a_str || a_mod || a_sht || a_sta;
    wire restart_en = dbr[pdss_pkg::PDSS_RESTART_BIT];
    wire shut_flag  = st != pdss_pkg::PDSS_RUN;
    wire sw_clear   = wr && a_sht && !PWDATA[pdss_pkg::PDSS_SHUT_BIT];
    wire sw_set     = wr && a_sht && PWDATA[pdss_pkg::PDSS_SHUT_BIT];
    wire [31:0] rd_mux =
        a_dbr ? {24'h0, dbr} :
        a_str ? {27'h0, steer} :
        a_mod ? {24'h0, mode} :
        a_sht ? {24'h0, shut_flag, shut[6:0]} :
        a_sta ? {28'h0, steer_eff} : 32'h0;
    assign PREADY  = 1'b1;
    assign PSLVERR = acc && !mapped;
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            dbr    <= pdss_pkg::PDSS_RST_DBR;
            steer  <= pdss_pkg::PDSS_RST_STEER;
            mode   <= pdss_pkg::PDSS_RST_MODE;
            shut   <= pdss_pkg::PDSS_RST_SHUT;
            PRDATA <= 32'h0;
        end else begin
            if (wr && a_dbr) dbr <= PWDATA[7:0];
            if (wr && a_str) steer <= PWDATA[4:0];
            if (wr && a_mod) mode <= PWDATA[7:0];
            if (wr && a_sht) shut <= PWDATA[7:0];
            if (PSEL && !PENABLE && !PWRITE) PRDATA <= rd_mux;
        end
    end

    // ***************************************************************
    // steering update
    // ***************************************************************
    wire sync_mode = steer[pdss_pkg::PDSS_SYNC_BIT];
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            steer_eff <= pdss_pkg::PDSS_RST_STEER[3:0];
            per_d     <= 1'b0;
        end else begin
            if (run) per_d <= per_lvl;
            if (!sync_mode) steer_eff <= steer[3:0];  // [RULE11]
            else if (per_start) steer_eff <= steer[3:0];  // [RULE12]
        end
    end

    // ***************************************************************
    // shutdown and restart
    // ***************************************************************
    pdss_pkg::pdss_state_e next_st;
    always_comb begin
        next_st = st;
        case (st)
            pdss_pkg::PDSS_RUN: begin
                if (fault || sw_set) next_st = pdss_pkg::PDSS_SHUT;
            end
            pdss_pkg::PDSS_SHUT: begin
                // fault level blocks software clear
                if (!fault && (restart_en || sw_clear))
                    next_st = pdss_pkg::PDSS_WAIT;  // [RULE4] [RULE5]
            end
            pdss_pkg::PDSS_WAIT: begin
                if (fault) next_st = pdss_pkg::PDSS_SHUT;
                else if (per_start) next_st = pdss_pkg::PDSS_RUN;  // [RULE18]
            end
            default: next_st = pdss_pkg::PDSS_RUN;
        endcase
    end
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) st <= pdss_pkg::PDSS_RUN;
        else if (!SLEEP) st <= next_st;  // [RULE13]
    end
    wire force_shut = fault || st != pdss_pkg::PDSS_RUN;  // [RULE17]

    // ***************************************************************
    // dead band
    // ***************************************************************
    wire single = mode[3:2] == pdss_pkg::PDSS_MODE_PWM
               && mode[7:6] == pdss_pkg::PDSS_BR_SINGLE;  // [RULE6]
    wire half   = mode[3:2] == pdss_pkg::PDSS_MODE_PWM
               && mode[7:6] == pdss_pkg::PDSS_BR_HALF;
    logic [1:0] instruction_cycle;
    logic [6:0] dcnt;
    logic       pwm_a;
    logic       pwm_b;
    logic       pwm_prev;
    wire        tcy_end = run && instruction_cycle == pdss_pkg::PDSS_TCY_LAST;  // [RULE2]
    wire        pwm_edge = pwm_raw != pwm_prev;
    // band ends with the last instruction cycle of the count
    wire        band_done = pwm_edge ? dbr[6:0] == 7'h0
                          : (dcnt == 7'h0 || (dcnt == 7'h1 && tcy_end));  // [RULE3] [RULE19]
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            instruction_cycle      <= 2'h0;
            dcnt     <= 7'h0;
            pwm_a    <= 1'b0;
            pwm_b    <= 1'b0;
            pwm_prev <= 1'b0;
        end else if (run) begin
            // cycle phase restarts at each edge, so the band is exact
            instruction_cycle      <= pwm_edge ? 2'h0 : instruction_cycle + 2'h1;  // [RULE2]
            pwm_prev <= pwm_raw;
            if (pwm_edge) dcnt <= dbr[6:0];  // [RULE3]
            else if (tcy_end && dcnt != 7'h0) dcnt <= dcnt - 7'h1;
            // falling side goes straight to inactive
            pwm_a <= pwm_raw && (!half || band_done);  // [RULE1] [RULE19]
            pwm_b <= !pwm_raw && (!half || band_done);  // [RULE1]
        end
    end

    // ***************************************************************
    // pin steering
    // ***************************************************************
    logic [3:0] next_out;
    logic [3:0] next_oe;
    for (genvar i = 0; i < 4; i++) begin : g_pin
        wire base = half ? ((i % 2 == 0) ? pwm_a : pwm_b) : pwm_a;
        wire pol  = (i % 2 == 0) ? mode[0] : mode[1];
        wire en   = single ? steer_eff[i] : (half && i < 2);  // [RULE7] [RULE8]
        wire [1:0] ss = (i % 2 == 0) ? shut[3:2] : shut[1:0];
        always_comb begin
            next_out[i] = PORT_OUT[i];
            next_oe[i]  = !PIN_DIRECTION_BITS[i];
            if (en) begin
                next_out[i] = base ^ pol;  // [RULE9]
                if (force_shut) begin
                    next_out[i] = ss == pdss_pkg::PDSS_SS_HIGH;  // [RULE10] [RULE17]
                    if (ss[1]) next_oe[i] = 1'b0;
                end
                next_oe[i] = next_oe[i] && !PIN_DIRECTION_BITS[i];  // [RULE15]
            end
        end
    end
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            PWM_OUT <= 4'h0;
            PWM_OE  <= 4'h0;
        end else if (!SLEEP) begin
            PWM_OUT <= next_out;
            PWM_OE  <= next_oe;
        end
    end

    // ***************************************************************
    // checks
    // ***************************************************************
    property p_shut_pins;
        @(posedge REF_CLK) disable iff (!RSTN)
        (!SLEEP && single && steer_eff[0] && fault && shut[3:2] == pdss_pkg::PDSS_SS_LOW)
            |=> PWM_OUT[0] == 1'b0;
    endproperty
    a_shut_pins: assert property (p_shut_pins) else $error("shutdown level wrong"); // [RULE17]
    property p_sleep;
        @(posedge REF_CLK) disable iff (!RSTN)
        SLEEP |=> $stable(PWM_OUT) && $stable(st);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep changed state"); // [RULE13]
    property p_restart;
        @(posedge REF_CLK) disable iff (!RSTN)
        (st == pdss_pkg::PDSS_WAIT && !$past(st == pdss_pkg::PDSS_WAIT))
            |-> $past(!fault);
    endproperty
    a_restart: assert property (p_restart) else $error("restart with fault"); // [RULE4]
    property p_run_at_period;
        @(posedge REF_CLK) disable iff (!RSTN)
        $rose(st == pdss_pkg::PDSS_RUN) |-> $past(per_start);
    endproperty
    a_run_at_period: assert property (p_run_at_period) else $error("resume off period"); // [RULE18]
    property p_sync;
        @(posedge REF_CLK) disable iff (!RSTN)
        (sync_mode && !per_start) |=> $stable(steer_eff);
    endproperty
    a_sync: assert property (p_sync) else $error("steer changed mid period"); // [RULE12]
    property p_async;
        @(posedge REF_CLK) disable iff (!RSTN)
        !sync_mode |=> steer_eff == $past(steer[3:0]);
    endproperty
    a_async: assert property (p_async) else $error("steer not immediate"); // [RULE11]
    property p_dir;
        @(posedge REF_CLK) disable iff (!RSTN)
        (!SLEEP && PIN_DIRECTION_BITS[1]) |=> !PWM_OE[1];
    endproperty
    a_dir: assert property (p_dir) else $error("driver on while input"); // [RULE15]
    property p_nosteer;
        @(posedge REF_CLK) disable iff (!RSTN)
        (!SLEEP && single && !steer_eff[2]) |=> PWM_OUT[2] == $past(PORT_OUT[2]);
    endproperty
    a_nosteer: assert property (p_nosteer) else $error("port control lost"); // [RULE7]

    // ***************************************************************
    // checks: dead band, clocks, shutdown and restart
    // ***************************************************************
    property p_band;
        @(posedge REF_CLK) disable iff (!RSTN)
        (half && run && pwm_edge && dbr[6:0] != 7'h0)
            |=> !pwm_a && !pwm_b;
    endproperty
    a_band: assert property (p_band) else $error("active edge not delayed"); // [RULE1]
    property p_zero;
        @(posedge REF_CLK) disable iff (!RSTN)
        (half && run && pwm_edge && dbr[6:0] == 7'h0)
            |=> pwm_a == $past(pwm_raw) && pwm_b == !$past(pwm_raw);
    endproperty
    a_zero: assert property (p_zero) else $error("zero band delayed"); // [RULE19]
    property p_load;
        @(posedge REF_CLK) disable iff (!RSTN)
        (run && pwm_edge)
            |=> dcnt == $past(dbr[6:0]);
    endproperty
    a_load: assert property (p_load) else $error("band count not loaded"); // [RULE3]
    property p_pm;
        @(posedge REF_CLK) disable iff (!RSTN)
        (PM_CLK_SEL && !pm_tick)
            |=> $stable(instruction_cycle) && $stable(pwm_a);
    endproperty
    a_pm: assert property (p_pm) else $error("ran without pm tick"); // [RULE14]
    property p_auto;
        @(posedge REF_CLK) disable iff (!RSTN)
        (st == pdss_pkg::PDSS_SHUT && restart_en && !fault && !SLEEP)
            |=> st == pdss_pkg::PDSS_WAIT;
    endproperty
    a_auto: assert property (p_auto) else $error("auto restart missed"); // [RULE4]
    property p_wait;
        @(posedge REF_CLK) disable iff (!RSTN)
        (st == pdss_pkg::PDSS_WAIT && !fault && !per_start && !SLEEP)
            |=> st == pdss_pkg::PDSS_WAIT;
    endproperty
    a_wait: assert property (p_wait) else $error("restart before period"); // [RULE18]
    property p_free;
        @(posedge REF_CLK) disable iff (!RSTN)
        (!SLEEP && single && !steer_eff[1] && force_shut)
            |=> PWM_OUT[1] == $past(PORT_OUT[1]);
    endproperty
    a_free: assert property (p_free) else $error("free pin forced"); // [RULE10]
    property p_stat;
        @(posedge REF_CLK) disable iff (!RSTN)
        (PSEL && !PENABLE && !PWRITE && a_sht)
            |=> PRDATA[7] == $past(shut_flag);
    endproperty
    a_stat: assert property (p_stat) else $error("status read wrong"); // [RULE4]
    c_shut: cover property (@(posedge REF_CLK) st == pdss_pkg::PDSS_SHUT);
    c_wait: cover property (@(posedge REF_CLK) st == pdss_pkg::PDSS_WAIT ##1 st == pdss_pkg::PDSS_RUN);
    c_dead: cover property (@(posedge REF_CLK) half && dcnt != 7'h0);
    c_sync: cover property (@(posedge REF_CLK) sync_mode && per_start);
endmodule

/* tb/pdss_drv_model.sv */
// switch driver inputs seen on the four pwm pins
// assumes a pull-down on every pin while the stage releases it
`timescale 1ns/1ps
module pdss_drv_model (
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    output logic      [3:0] pin_level
);
    // ****************************************************
    // pin resolution
    // ****************************************************
    // released pin pulled low, keeps the switch off
    assign pin_level = pin_out & pin_oe;
endmodule

/* tb/pdss_stage_tb_top.sv */
// self-checking bench of the dead-band and steering stage
// assumes pdss_pkg compiled first, PORT_OUT tied to 4'ha
`timescale 1ns/1ps
module pdss_stage_tb_top;
    typedef struct packed {
        logic [3:0] steer;
        logic [1:0] pol;
        logic       pwm;
        logic [3:0] dir;
        logic [3:0] lvl;
        logic [3:0] oe;
    } pdss_row_s;
    logic        ref_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, perr;
    logic        pwm_in = 0, period_start = 0, shutdown_in = 0, sleep = 0, pslverr;
    logic        pm_sel = 0, pm_tick = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  dir = 4'h0, pwm_out, pwm_oe, lvl;
    int          errors = 0, num_checks = 0, c0, f0, c3, f3;
    pdss_row_s   rows[8] = '{'{4'h1, 2'h0, 1'b1, 4'h0, 4'hb, 4'hf},
        '{4'h1, 2'h0, 1'b0, 4'h0, 4'ha, 4'hf}, '{4'hf, 2'h0, 1'b1, 4'h0, 4'hf, 4'hf},
        '{4'hf, 2'h1, 1'b0, 4'h0, 4'h5, 4'hf}, '{4'h6, 2'h2, 1'b1, 4'h0, 4'hc, 4'hf},
        '{4'hf, 2'h0, 1'b1, 4'h5, 4'ha, 4'ha}, '{4'h8, 2'h3, 1'b1, 4'h0, 4'h2, 4'hf},
        '{4'hf, 2'h0, 1'b1, 4'ha, 4'h5, 4'h5}};
    always #10 ref_clk = ~ref_clk;
    pdss_stage i_pdss_stage (.REF_CLK(ref_clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .PWM_IN(pwm_in), .PERIOD_START(period_start),
        .SHUTDOWN_IN(shutdown_in), .SLEEP(sleep), .PM_TICK(pm_tick), .PM_CLK_SEL(pm_sel),
        .PIN_DIRECTION_BITS(dir), .PORT_OUT(4'ha), .PWM_OUT(pwm_out), .PWM_OE(pwm_oe));
    pdss_drv_model i_pdss_drv_model (.pin_out(pwm_out), .pin_oe(pwm_oe), .pin_level(lvl));
    // ****************************************************
    // tasks
    // ****************************************************
    task close_out;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            close_out;
        end
        rd = prdata;
        perr = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task settle;
        repeat (6) @(posedge ref_clk);
    endtask
    task per;
        @(posedge ref_clk) period_start <= 1;
        settle;
        period_start <= 0;
        settle;
    endtask
    task meas(input logic v, output int c);
        @(posedge ref_clk) pwm_in <= v;
        c = 0;
        do begin
            @(negedge ref_clk);
            c++;
        end while (pwm_out[0] !== v && c < 1000);
        if (c >= 1000) begin
            errors++;
            close_out;
        end
    endtask
    // ****************************************************
    // sequence
    // ****************************************************
    initial begin
        repeat (5) @(posedge ref_clk);
        rstn <= 1;
        for (int i = 0; i < 4; i++) begin
            apb(0, 12'(4 * i), 32'h0);
            chk("reset value", rd, (i == 1) ? 32'h1 : 32'h0);
        end
        apb(0, 12'h020, 32'h0);
        chk("unmapped err", 32'(perr), 32'h1);
        $display("test registers done");
        foreach (rows[i]) begin
            apb(1, pdss_pkg::PDSS_ADDR_MODE, 32'h0c | 32'(rows[i].pol));
            apb(1, pdss_pkg::PDSS_ADDR_STEER, 32'(rows[i].steer));
            pwm_in <= rows[i].pwm;
            dir <= rows[i].dir;
            settle;
            chk("row level", 32'(lvl), 32'(rows[i].lvl));
            chk("row enable", 32'(pwm_oe), 32'(rows[i].oe));
        end
        apb(1, pdss_pkg::PDSS_ADDR_MODE, 32'h4c);
        dir <= 4'h0;
        settle;
        chk("steer off mode", 32'(lvl), 32'ha);
        $display("test steering rows done");
        apb(1, pdss_pkg::PDSS_ADDR_MODE, 32'h0c);
        apb(1, pdss_pkg::PDSS_ADDR_STEER, 32'h01);
        dir <= 4'h0;
        pwm_in <= 1'b1;
        apb(1, pdss_pkg::PDSS_ADDR_STEER, 32'h12);
        settle;
        chk("sync held", 32'(lvl), 32'hb);
        apb(0, pdss_pkg::PDSS_ADDR_STAT, 32'h0);
        chk("sync held status", rd, 32'h1);
        per;
        chk("sync applied", 32'(lvl), 32'ha);
        apb(0, pdss_pkg::PDSS_ADDR_STAT, 32'h0);
        chk("sync applied status", rd, 32'h2);
        $display("test steering sync done");
        apb(1, pdss_pkg::PDSS_ADDR_STEER, 32'h05);
        pwm_in <= 1'b0;
        apb(1, pdss_pkg::PDSS_ADDR_SHUT, 32'h04);
        apb(1, pdss_pkg::PDSS_ADDR_DBR, 32'h80);
        shutdown_in <= 1'b1;
        settle;
        chk("shut level", 32'(lvl), 32'hf);
        apb(0, pdss_pkg::PDSS_ADDR_SHUT, 32'h0);
        chk("shut status", 32'(rd[7]), 32'h1);
        apb(1, pdss_pkg::PDSS_ADDR_SHUT, 32'h00);
        settle;
        chk("shut low", 32'(lvl), 32'ha);
        chk("shut low enable", 32'(pwm_oe), 32'hf);
        apb(1, pdss_pkg::PDSS_ADDR_SHUT, 32'h08);
        settle;
        chk("shut tristate", 32'(pwm_oe), 32'ha);
        shutdown_in <= 1'b0;
        settle;
        chk("restart wait", 32'(pwm_oe), 32'ha);
        per;
        apb(0, pdss_pkg::PDSS_ADDR_SHUT, 32'h0);
        chk("auto clear", 32'(rd[7]), 32'h0);
        chk("restart oe", 32'(pwm_oe), 32'hf);
        apb(1, pdss_pkg::PDSS_ADDR_DBR, 32'h00);
        shutdown_in <= 1'b1;
        settle;
        shutdown_in <= 1'b0;
        settle;
        per;
        apb(0, pdss_pkg::PDSS_ADDR_SHUT, 32'h0);
        chk("manual hold", 32'(rd[7]), 32'h1);
        chk("manual hold enable", 32'(pwm_oe), 32'ha);
        apb(1, pdss_pkg::PDSS_ADDR_SHUT, 32'h00);
        per;
        apb(0, pdss_pkg::PDSS_ADDR_SHUT, 32'h0);
        chk("manual clear", 32'(rd[7]), 32'h0);
        chk("manual restart oe", 32'(pwm_oe), 32'hf);
        $display("test shutdown done");
        apb(1, pdss_pkg::PDSS_ADDR_DBR, 32'h00);
        apb(1, pdss_pkg::PDSS_ADDR_MODE, 32'h8c);
        settle;
        meas(1'b1, c0);
        settle;
        meas(1'b0, f0);
        apb(1, pdss_pkg::PDSS_ADDR_DBR, 32'h03);
        settle;
        meas(1'b1, c3);
        settle;
        meas(1'b0, f3);
        // two sync flops, band flop, pin flop, seen half a cycle on
        chk("zero count", 32'(c0), 32'h5);
        chk("band delay", 32'(c3 - c0), 32'(3 * pdss_pkg::PDSS_TCY_OSC));
        chk("fall undelayed", 32'(f3), 32'(f0));
        $display("test dead band done");
        apb(1, pdss_pkg::PDSS_ADDR_MODE, 32'h0c);
        apb(1, pdss_pkg::PDSS_ADDR_STEER, 32'h01);
        settle;
        sleep <= 1'b1;
        pwm_in <= 1'b1;
        settle;
        chk("sleep hold", 32'(lvl), 32'ha);
        sleep <= 1'b0;
        settle;
        chk("wake resume", 32'(lvl), 32'hb);
        $display("test sleep done");
        pm_sel <= 1'b1;
        pwm_in <= 1'b0;
        settle;
        chk("pm no tick", 32'(lvl), 32'hb);
        pm_tick <= 1'b1;
        settle;
        chk("pm tick", 32'(lvl), 32'ha);
        pm_sel <= 1'b0;
        pm_tick <= 1'b0;
        $display("test power clock done");
        close_out;
    end
endmodule
